// ### verilog/crs_pkg.sv
// Purpose: shared constants for the receive object store
// Assumes: one clock, synchronous active-low reset
// Notes: word indices address the lookup ram and handler registers
package crs_pkg;
    // ram geometry
    localparam int          RAM_WORDS     = 512;
    localparam int          AW            = 10;
    localparam int          OBJ_WORDS     = 3;
    localparam logic [7:0]  MAX_OBJECTS   = 8'd146;
    localparam logic [7:0]  IRQ_OBJECTS   = 8'd64;
    // handler register word indices
    localparam logic [9:0]  IDX_PEND_LO   = 10'h200;
    localparam logic [9:0]  IDX_PEND_HI   = 10'h201;
    localparam logic [9:0]  IDX_GIE       = 10'h202;
    localparam logic [9:0]  IDX_TAB_END   = 10'h203;
    // head word field positions
    localparam int          HB_FF         = 31;
    localparam int          HB_RTR        = 30;
    localparam int          HB_SEM_HI     = 25;
    localparam int          HB_SEM_LO     = 24;
    localparam int          HB_DLC_LO     = 16;
    localparam int          HB_SCC_LO     = 13;
    localparam int          HB_IEN        = 12;
    localparam int          HB_LOST       = 11;
    // semaphore codes
    localparam logic [1:0]  SEM_UPDATING  = 2'b01;
    localparam logic [1:0]  SEM_DONE      = 2'b11;
    localparam logic [1:0]  SEM_READING   = 2'b00;
    // reset values
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [11:0] RST_TAB_END   = 12'h000;
    // host register byte offsets
    localparam logic [7:0]  HR_CMD        = 8'h00;
    localparam logic [7:0]  HR_STATUS     = 8'h04;
    localparam logic [7:0]  HR_SNAP0      = 8'h08;
    localparam logic [7:0]  HR_SNAP1      = 8'h0c;
    localparam logic [7:0]  HR_SNAP2      = 8'h10;
    localparam logic [7:0]  HR_PEND_LO    = 8'h14;
    localparam logic [7:0]  HR_PEND_HI    = 8'h18;
    localparam logic [7:0]  HR_RAW_ADDR   = 8'h1c;
    localparam logic [7:0]  HR_RAW_DATA   = 8'h20;
    localparam logic [7:0]  HR_RAW_FETCH  = 8'h24;
    // host status bits
    localparam int          ST_BUSY       = 0;
    localparam int          ST_OK         = 1;
    localparam int          ST_DISCARD    = 2;
    localparam int          ST_NOTREADY   = 3;
endpackage : crs_pkg

// ### verilog/crs_if.sv
// Purpose: link between the object store handler and the cpu side
// Assumes: both ends on clk, handler never stalls the cpu
// Notes: read data valid the cycle after cpu_re
`timescale 1ns/1ps
interface crs_if (
    input wire logic clk,
    input wire logic rst_b
);
    logic        cpu_we;
    logic        cpu_re;
    logic [9:0]  cpu_addr;
    logic [31:0] cpu_wdata;
    logic [31:0] cpu_rdata;
    logic [31:0] pend_lo;
    logic [31:0] pend_hi;
    logic [11:0] tab_end;

    modport handler (
        input  clk, rst_b, cpu_we, cpu_re, cpu_addr, cpu_wdata,
        output cpu_rdata, pend_lo, pend_hi, tab_end
    );
    modport cpu (
        input  clk, rst_b, cpu_rdata, pend_lo, pend_hi, tab_end,
        output cpu_we, cpu_re, cpu_addr, cpu_wdata
    );
endinterface : crs_if

// ### verilog/crs_handler.sv
// Purpose: stores accepted frames into three-word objects of the lookup ram
// Assumes: frame source holds rx inputs steady while rx_valid_i and !rx_ready_o
// Notes: cpu writes always win the ram port; the handler waits one cycle
// What this block does; RL5-RL7 and RL18 fall to the software side
// [RL1] object is head, data 1-4, data 5-8
// [RL2] semaphore 01 updating, 11 done, 00 reading
// [RL3] head with semaphore 01 written first
// [RL4] semaphore set 11 after last data
// [RL5] software samples semaphore before reading
// [RL6] software writes semaphore 00 before reading
// [RL7] software keeps data only if still 00
// [RL8] ram is 2 kB, at most 146 objects
// [RL9] only objects 0-63 raise interrupts
// [RL10] pending set on last write if enabled
// [RL11] interrupt forwarded only with global enable
// [RL12] pending clears when software clears semaphore
// [RL13] first write sets lost if pending
// [RL14] first write clears lost if not pending
// [RL15] enable and lost bits live in ram
// [RL16] source channel stored with the frame
// [RL17] overwrite during read sets pending again
// [RL18] software picks service order from bits
// [RL19] objects 0-31 low word, 32-63 high
// [RL20] object at table end plus index times 12
// [RL21] global enable bit 0, off-mode writes only
// [RL22] interrupt is or of pending, gated
// [RL23] colliding writes serialized, none lost
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module crs_handler
    import crs_pkg::*;
(
    // cpu side link
    crs_if.handler       bus,
    // receive path from the can controller
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    input  wire logic [7:0]  rx_index_i,
    input  wire logic        rx_ff_i,
    input  wire logic        rx_rtr_i,
    input  wire logic [3:0]  rx_dlc_i,
    input  wire logic [10:0] rx_id_i,
    input  wire logic [2:0]  rx_scc_i,
    input  wire logic [63:0] rx_data_i,
    // filter mode and interrupt
    input  wire logic        filter_off_i,
    output logic             irq_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HEAD = 3'b001,
        ST_LO   = 3'b010,
        ST_HI   = 3'b011,
        ST_SEM  = 3'b100
    } crs_hstate_t;

    logic [31:0]  ram [0:RAM_WORDS-1];
    crs_hstate_t  state_reg, state_next;
    logic [63:0]  pend_reg, pend_next;
    logic         gie_reg;
    logic [11:0]  tab_end_reg;
    logic [31:0]  rdata_reg;
    logic [7:0]   obj_reg;
    logic         ff_reg, rtr_reg, lost_reg;
    logic [3:0]   dlc_reg;
    logic [10:0]  id_reg;
    logic [2:0]   scc_reg;
    logic [63:0]  data_reg;

    // object base word: table end plus index times three words
    wire  [9:0]  tab_word  = tab_end_reg[11:2];
    wire  [10:0] obj_base  = {1'b0, tab_word} + 11'(obj_reg) * 11'd3; // [RL20]
    wire         obj_irq   = obj_reg < IRQ_OBJECTS; // [RL9]
    wire         obj_in    = obj_reg < MAX_OBJECTS && obj_base < 11'(RAM_WORDS - 2); // [RL8]
    wire  [31:0] head_old  = ram[obj_base[8:0]];
    wire         ien       = head_old[HB_IEN]; // [RL15]
    wire         pend_cur  = obj_irq && pend_reg[obj_reg[5:0]];

    // handler write port, stalled by a cpu write
    wire         cpu_ram_we = bus.cpu_we && bus.cpu_addr < AW'(RAM_WORDS);
    wire         h_busy     = state_reg != ST_IDLE;
    wire         h_go       = h_busy && !bus.cpu_we; // [RL23]
    logic        h_we;
    logic [8:0]  h_addr;
    logic [31:0] h_wdata;
    logic [1:0]  h_sem;
    logic        h_lost;

    // head word, enable bit kept from the stored word
    wire  [31:0] head_new = {ff_reg, rtr_reg, 4'h0, h_sem, 4'h0, dlc_reg,
                             scc_reg, ien, h_lost, id_reg}; // [RL1] [RL16]

    // next state and write selection
    always_comb begin
        state_next = state_reg;
        h_we       = 1'b0;
        h_addr     = obj_base[8:0];
        h_sem      = SEM_UPDATING;
        h_lost     = lost_reg;
        h_wdata    = head_new;
        case (state_reg)
            ST_IDLE: begin
                if (rx_valid_i) begin
                    state_next = ST_HEAD;
                end
            end
            ST_HEAD: begin
                h_sem  = SEM_UPDATING; // [RL3] [RL2]
                h_lost = pend_cur; // [RL13] [RL14]
                h_we   = h_go && obj_in;
                if (h_go) begin
                    state_next = obj_in ? ST_LO : ST_IDLE;
                end
            end
            ST_LO: begin
                h_addr  = obj_base[8:0] + 9'd1;
                h_wdata = data_reg[31:0]; // [RL1]
                h_we    = h_go;
                if (h_go) begin
                    state_next = ST_HI;
                end
            end
            ST_HI: begin
                h_addr  = obj_base[8:0] + 9'd2;
                h_wdata = data_reg[63:32]; // [RL1]
                h_we    = h_go;
                if (h_go) begin
                    state_next = ST_SEM;
                end
            end
            ST_SEM: begin
                h_sem = SEM_DONE; // [RL4] [RL2]
                h_we  = h_go;
                if (h_go) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign rx_ready_o = state_reg == ST_IDLE;

    // cpu write decode for semaphore clears
    wire  [10:0] cpu_rel   = {1'b0, bus.cpu_addr} - {1'b0, tab_word};
    wire  [10:0] cpu_obj   = cpu_rel / 11'd3;
    wire  [10:0] cpu_rem   = cpu_rel - cpu_obj * 11'd3;
    wire         cpu_head  = cpu_ram_we && bus.cpu_addr >= {1'b0, tab_word} && cpu_rem == 11'd0
                             && cpu_obj < 11'(IRQ_OBJECTS);
    wire         sem_clear = cpu_head && bus.cpu_wdata[HB_SEM_HI:HB_SEM_LO] == SEM_READING;
    wire  [63:0] clr_mask  = sem_clear ? (64'h1 << cpu_obj[5:0]) : 64'h0; // [RL12]

    // pending set during the final head write, enabled objects only
    wire         pend_set  = state_reg == ST_SEM && h_go && obj_irq && ien; // [RL10] [RL17]
    wire  [63:0] set_mask  = pend_set ? (64'h1 << obj_reg[5:0]) : 64'h0;

    // set wins over a clear in the same cycle
    always_comb begin
        pend_next = (pend_reg & ~clr_mask) | set_mask;
    end

    // global enable write only while the filter is off
    wire gie_we = bus.cpu_we && bus.cpu_addr == IDX_GIE && filter_off_i; // [RL21]
    wire te_we  = bus.cpu_we && bus.cpu_addr == IDX_TAB_END;

    // ram: cpu first, handler otherwise, never both
    always_ff @(posedge bus.clk) begin
        if (cpu_ram_we) begin
            ram[bus.cpu_addr[8:0]] <= bus.cpu_wdata; // [RL23]
        end else if (h_we) begin
            ram[h_addr] <= h_wdata;
        end
    end

    // read mux, one cycle later
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = RST_WORD;
        if (bus.cpu_addr < AW'(RAM_WORDS)) begin
            rd_mux = ram[bus.cpu_addr[8:0]];
        end else if (bus.cpu_addr == IDX_PEND_LO) begin
            rd_mux = pend_reg[31:0]; // [RL19]
        end else if (bus.cpu_addr == IDX_PEND_HI) begin
            rd_mux = pend_reg[63:32]; // [RL19]
        end else if (bus.cpu_addr == IDX_GIE) begin
            rd_mux = {31'h0, gie_reg};
        end else if (bus.cpu_addr == IDX_TAB_END) begin
            rd_mux = {20'h0, tab_end_reg};
        end
    end

    // control registers
    always_ff @(posedge bus.clk) begin
        if (!bus.rst_b) begin
            state_reg   <= ST_IDLE;
            pend_reg    <= 64'h0;
            gie_reg     <= 1'b0;
            tab_end_reg <= RST_TAB_END;
            rdata_reg   <= RST_WORD;
            lost_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg  <= pend_next;
            if (gie_we) begin
                gie_reg <= bus.cpu_wdata[0];
            end
            if (te_we) begin
                tab_end_reg <= {bus.cpu_wdata[11:2], 2'b00};
            end
            if (bus.cpu_re) begin
                rdata_reg <= rd_mux;
            end
            if (state_reg == ST_HEAD && h_go) begin
                lost_reg <= pend_cur; // [RL13] [RL14]
            end
        end
    end

    // frame capture when a new frame is taken
    always_ff @(posedge bus.clk) begin
        if (!bus.rst_b) begin
            obj_reg  <= 8'h00;
            ff_reg   <= 1'b0;
            rtr_reg  <= 1'b0;
            dlc_reg  <= 4'h0;
            id_reg   <= 11'h000;
            scc_reg  <= 3'h0;
            data_reg <= 64'h0;
        end else if (rx_ready_o && rx_valid_i) begin
            obj_reg  <= rx_index_i;
            ff_reg   <= rx_ff_i;
            rtr_reg  <= rx_rtr_i;
            dlc_reg  <= rx_dlc_i;
            id_reg   <= rx_id_i;
            scc_reg  <= rx_scc_i; // [RL16]
            data_reg <= rx_data_i;
        end
    end

    // interrupt: registered or of all pending flags, gated
    always_ff @(posedge bus.clk) begin
        if (!bus.rst_b) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= gie_reg && |pend_reg; // [RL11] [RL22]
        end
    end

    assign bus.cpu_rdata = rdata_reg;
    assign bus.pend_lo   = pend_reg[31:0];
    assign bus.pend_hi   = pend_reg[63:32];
    assign bus.tab_end   = tab_end_reg;
endmodule : crs_handler

// ### verilog/crs_cpu.sv
// Purpose: cpu side: consistent object snapshot and raw ram access
// Assumes: software strobes one cycle, read data taken the next cycle
// Notes: commands arriving while busy are ignored
`timescale 1ns/1ps
module crs_cpu
    import crs_pkg::*;
(
    // link to the handler
    crs_if.cpu           bus,
    // software register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o
);
    typedef enum logic [2:0] {
        CS_IDLE  = 3'b000,
        CS_CHK   = 3'b001,
        CS_CLR   = 3'b010,
        CS_RD1   = 3'b011,
        CS_RD2   = 3'b100,
        CS_AGAIN = 3'b101,
        CS_FINAL = 3'b110
    } crs_cstate_t;

    crs_cstate_t state_reg, state_next;
    logic [9:0]  base_reg;
    logic [31:0] snap_reg [0:2];
    logic [3:0]  stat_reg;
    logic [9:0]  raw_addr_reg;
    logic [31:0] raw_data_reg;
    logic        raw_pend_reg;
    logic [31:0] rdata_reg;

    // decode of software strobes
    wire idle     = state_reg == CS_IDLE;
    wire cmd_go   = wr_i && addr_i == HR_CMD && idle;
    wire raw_wr   = wr_i && addr_i == HR_RAW_DATA && idle;
    wire raw_rd   = wr_i && addr_i == HR_RAW_FETCH && idle;
    wire [10:0] base_calc = {1'b0, bus.tab_end[11:2]} + 11'(wdata_i[7:0]) * 11'd3;
    wire [1:0]  sem_rd    = bus.cpu_rdata[HB_SEM_HI:HB_SEM_LO];

    // link drive and sequencing
    always_comb begin
        state_next    = state_reg;
        bus.cpu_we    = 1'b0;
        bus.cpu_re    = 1'b0;
        bus.cpu_addr  = base_reg;
        bus.cpu_wdata = snap_reg[0];
        case (state_reg)
            CS_IDLE: begin
                if (cmd_go) begin
                    bus.cpu_re   = 1'b1;
                    bus.cpu_addr = base_calc[9:0]; // [RL5]
                    state_next   = CS_CHK;
                end else if (raw_wr || raw_rd) begin
                    bus.cpu_we    = raw_wr;
                    bus.cpu_re    = raw_rd;
                    bus.cpu_addr  = raw_addr_reg;
                    bus.cpu_wdata = wdata_i;
                end
            end
            CS_CHK: begin
                state_next = sem_rd == SEM_DONE ? CS_CLR : CS_IDLE; // [RL5]
            end
            CS_CLR: begin
                bus.cpu_we    = 1'b1;
                bus.cpu_wdata = {snap_reg[0][31:HB_SEM_HI+1], SEM_READING,
                                 snap_reg[0][HB_SEM_LO-1:0]}; // [RL6]
                state_next    = CS_RD1;
            end
            CS_RD1: begin
                bus.cpu_re   = 1'b1;
                bus.cpu_addr = base_reg + 10'd1;
                state_next   = CS_RD2;
            end
            CS_RD2: begin
                bus.cpu_re   = 1'b1;
                bus.cpu_addr = base_reg + 10'd2;
                state_next   = CS_AGAIN;
            end
            CS_AGAIN: begin
                bus.cpu_re = 1'b1;
                state_next = CS_FINAL;
            end
            CS_FINAL: begin
                state_next = CS_IDLE;
            end
            default: begin
                state_next = CS_IDLE;
            end
        endcase
    end

    // snapshot capture and verdict
    always_ff @(posedge bus.clk) begin
        if (!bus.rst_b) begin
            state_reg    <= CS_IDLE;
            base_reg     <= 10'h000;
            stat_reg     <= 4'h0;
            raw_addr_reg <= 10'h000;
            raw_data_reg <= RST_WORD;
            raw_pend_reg <= 1'b0;
            snap_reg[0]  <= RST_WORD;
            snap_reg[1]  <= RST_WORD;
            snap_reg[2]  <= RST_WORD;
        end else begin
            state_reg    <= state_next;
            raw_pend_reg <= raw_rd;
            if (raw_pend_reg) begin
                raw_data_reg <= bus.cpu_rdata;
            end
            if (wr_i && addr_i == HR_RAW_ADDR) begin
                raw_addr_reg <= wdata_i[11:2];
            end
            if (cmd_go) begin
                base_reg <= base_calc[9:0];
                stat_reg <= 4'h1;
            end
            case (state_reg)
                CS_CHK: begin
                    snap_reg[0] <= bus.cpu_rdata;
                    if (sem_rd != SEM_DONE) begin
                        stat_reg <= 4'h8; // [RL5]
                    end
                end
                CS_RD2: snap_reg[1] <= bus.cpu_rdata;
                CS_AGAIN: snap_reg[2] <= bus.cpu_rdata;
                CS_FINAL: begin
                    // only a still-cleared semaphore proves one frame
                    stat_reg <= sem_rd == SEM_READING ? 4'h2 : 4'h4; // [RL7]
                end
                default: begin
                end
            endcase
        end
    end

    // software read data, one cycle after the strobe
    always_ff @(posedge bus.clk) begin
        if (!bus.rst_b) begin
            rdata_reg <= RST_WORD;
        end else if (rd_i) begin
            case (addr_i)
                HR_STATUS:   rdata_reg <= {28'h0, stat_reg};
                HR_SNAP0:    rdata_reg <= snap_reg[0];
                HR_SNAP1:    rdata_reg <= snap_reg[1];
                HR_SNAP2:    rdata_reg <= snap_reg[2];
                HR_PEND_LO:  rdata_reg <= bus.pend_lo; // [RL18]
                HR_PEND_HI:  rdata_reg <= bus.pend_hi; // [RL18]
                HR_RAW_ADDR: rdata_reg <= {20'h0, raw_addr_reg, 2'b00};
                HR_RAW_DATA: rdata_reg <= raw_data_reg;
                default:     rdata_reg <= RST_WORD;
            endcase
        end
    end

    assign rdata_o = rdata_reg;
endmodule : crs_cpu

// ### bench/crs_checker.sv
// Purpose: assertions on the handler to cpu link
// Assumes: one clock, synchronous active-low reset
// Notes: heads found from the table end register
`timescale 1ns/1ps
module crs_checker
    import crs_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // link signals
    input wire logic        cpu_we,
    input wire logic        cpu_re,
    input wire logic [9:0]  cpu_addr,
    input wire logic [31:0] cpu_wdata,
    input wire logic [31:0] cpu_rdata,
    input wire logic [31:0] pend_lo,
    input wire logic [31:0] pend_hi,
    input wire logic [11:0] tab_end
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // software clears the semaphore of the head of object 0 or 63
    sequence s_clear_first;
        cpu_we && cpu_addr == tab_end[11:2] && cpu_wdata[HB_SEM_HI:HB_SEM_LO] == SEM_READING;
    endsequence
    sequence s_clear_last;
        cpu_we && cpu_addr == tab_end[11:2] + 10'd189 && cpu_wdata[HB_SEM_HI:HB_SEM_LO] == SEM_READING;
    endsequence
    sequence s_tab_write;
        cpu_we && cpu_addr == IDX_TAB_END;
    endsequence

    a_clear_first: assert property (s_clear_first |=> !pend_lo[0])
        else $error("object 0 pending not cleared");
    a_clear_last: assert property (s_clear_last |=> !pend_hi[31])
        else $error("object 63 pending not cleared");
    a_pend_lo_read: assert property (cpu_re && cpu_addr == IDX_PEND_LO |=> cpu_rdata == $past(pend_lo))
        else $error("low pending read wrong");
    a_pend_hi_read: assert property (cpu_re && cpu_addr == IDX_PEND_HI |=> cpu_rdata == $past(pend_hi))
        else $error("high pending read wrong");
    a_unmapped_zero: assert property (cpu_re && cpu_addr > IDX_TAB_END |=> cpu_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_tab_end_load: assert property (s_tab_write |=> tab_end[11:2] == $past(cpu_wdata[11:2]))
        else $error("table end not loaded");
    a_tab_end_hold: assert property (!(cpu_we && cpu_addr == IDX_TAB_END) |=> $stable(tab_end))
        else $error("table end changed unwritten");
    a_rdata_hold: assert property (!cpu_re |=> $stable(cpu_rdata))
        else $error("read data changed unread");
    a_one_strobe: assert property (!(cpu_we && cpu_re))
        else $error("read and write together");
endmodule : crs_checker

// ### bench/test_can_rx_object_store_irq.sv
// Purpose: self-checking bench, handler and cpu side joined by the link
// Assumes: table end at 0x100, so object 146 still falls inside the ram
// Notes: random frames on boundary objects, raw writes race the handler
`timescale 1ns/1ps
module test_can_rx_object_store_irq;
    import crs_pkg::*;
    localparam logic [11:0] TAB = 12'h100;
    localparam int          OBJS [0:7] = '{0, 1, 31, 32, 63, 64, 100, 145};
    // stimulus and observed signals
    logic        clk_i, rst_b_i, wr_i, rd_i, rx_valid_i, rx_ready_o, rx_ff_i, rx_rtr_i, filter_off_i, irq_o;
    logic [7:0]  addr_i, rx_index_i;
    logic [31:0] wdata_i, rdata_o, rd_v, sv;
    logic [3:0]  rx_dlc_i;
    logic [10:0] rx_id_i;
    logic [2:0]  rx_scc_i;
    logic [63:0] rx_data_i, pend_m, d;
    logic [19:0] f;
    logic        ien_m [0:146];
    logic        lost;
    int          num_errors, n_checks, idx, n;

    crs_if crs_if_i (.clk(clk_i), .rst_b(rst_b_i));
    crs_handler crs_handler_i (.bus(crs_if_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .rx_index_i(rx_index_i), .rx_ff_i(rx_ff_i), .rx_rtr_i(rx_rtr_i), .rx_dlc_i(rx_dlc_i),
        .rx_id_i(rx_id_i), .rx_scc_i(rx_scc_i), .rx_data_i(rx_data_i), .filter_off_i(filter_off_i),
        .irq_o(irq_o));
    crs_cpu crs_cpu_i (.bus(crs_if_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o));
    crs_checker crs_checker_i (.clk(crs_if_i.clk), .rst_b(crs_if_i.rst_b), .cpu_we(crs_if_i.cpu_we),
        .cpu_re(crs_if_i.cpu_re), .cpu_addr(crs_if_i.cpu_addr), .cpu_wdata(crs_if_i.cpu_wdata),
        .cpu_rdata(crs_if_i.cpu_rdata), .pend_lo(crs_if_i.pend_lo), .pend_hi(crs_if_i.pend_hi),
        .tab_end(crs_if_i.tab_end));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // one strobe, then a quiet cycle in which read data are taken
    task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] dt);
        wr_i    <= w;
        rd_i    <= r;
        addr_i  <= a;
        wdata_i <= dt;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
        rd_v = rdata_o;
    endtask : bus

    task rd(input logic [7:0] a);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd

    task raw_wr(input logic [11:0] ba, input logic [31:0] dt);
        bus(1'b1, 1'b0, HR_RAW_ADDR, {20'h0, ba});
        bus(1'b1, 1'b0, HR_RAW_DATA, dt);
    endtask : raw_wr

    // fetch result is read two cycles after the fetch write
    task raw_rd(input logic [11:0] ba);
        bus(1'b1, 1'b0, HR_RAW_ADDR, {20'h0, ba});
        bus(1'b1, 1'b0, HR_RAW_FETCH, 32'h0);
        bus(1'b0, 1'b1, HR_RAW_DATA, 32'h0);
    endtask : raw_rd

    // raw or register read, then compare
    task chk(input string what, input logic raw, input logic [11:0] a, input logic [31:0] exp);
        if (raw) begin
            raw_rd(a);
        end else begin
            rd(a[7:0]);
        end
        check(what, exp, rd_v);
    endtask : chk

    // ready seen at the falling edge, so valid drops right after the taking edge
    task send(input int i, input logic [63:0] dt, input logic [19:0] fl);
        int k;
        rx_valid_i <= 1'b1;
        rx_index_i <= 8'(i);
        {rx_ff_i, rx_rtr_i, rx_dlc_i, rx_id_i, rx_scc_i} <= fl;
        rx_data_i  <= dt;
        k = 0;
        @(negedge clk_i);
        while (rx_ready_o !== 1'b1 && k < 50) begin
            @(negedge clk_i);
            k++;
        end
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        do begin
            @(negedge clk_i);
            k++;
        end while (rx_ready_o !== 1'b1 && k < 100);
        @(posedge clk_i);
        check("frame handshake", 32'h0, 32'(k >= 50));
    endtask : send

    function automatic logic [31:0] exp_head(input logic [19:0] fl, input logic ien, input logic ls);
        logic [31:0] h;
        h = 32'h0;
        h[HB_FF] = fl[19];
        h[HB_RTR] = fl[18];
        h[HB_SEM_HI:HB_SEM_LO] = SEM_DONE;
        h[HB_DLC_LO +: 4] = fl[17:14];
        h[HB_SCC_LO +: 3] = fl[2:0];
        h[HB_IEN] = ien;
        h[HB_LOST] = ls;
        h[10:0] = fl[13:3];
        return h;
    endfunction : exp_head

    task give_verdict;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // watchdog, well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end

    initial begin
        {wr_i, rd_i, rx_valid_i, rx_ff_i, rx_rtr_i, filter_off_i} = '0;
        {addr_i, rx_index_i, wdata_i, rx_dlc_i, rx_id_i, rx_scc_i, rx_data_i} = '0;
        rst_b_i = 1'b0;
        pend_m = '0;
        void'($urandom(37920));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(HR_STATUS);
        raw_wr(12'h80c, {20'h0, TAB});
        chk("table end", 1'b1, 12'h80c, {20'h0, TAB});
        filter_off_i <= 1'b1;
        raw_wr(12'h808, 32'h1);
        filter_off_i <= 1'b0;
        raw_wr(12'h808, 32'h0);
        chk("global enable", 1'b1, 12'h808, 32'h1);
        foreach (OBJS[j]) begin
            ien_m[OBJS[j]] = 1'($urandom_range(1, 0));
            raw_wr(12'(TAB + 12 * OBJS[j]), {19'h0, ien_m[OBJS[j]], 12'h0});
        end
        // object past the last one is taken but never stored
        raw_wr(12'(TAB + 12 * 146), 32'h5a5a_0001);
        send(146, {$urandom, $urandom}, 20'($urandom));
        chk("word past last object", 1'b1, 12'(TAB + 12 * 146), 32'h5a5a_0001);
        for (int k = 0; k < 40; k++) begin
            idx = OBJS[$urandom_range(7, 0)];
            f   = 20'($urandom);
            d   = {$urandom, $urandom};
            sv  = $urandom;
            if (k < 2 || $urandom_range(1, 0) == 1) begin
                ien_m[idx] = 1'($urandom_range(1, 0));
                raw_wr(12'(TAB + 12 * idx), {19'h0, ien_m[idx], 12'h0});
                if (idx < 64) pend_m[idx] = 1'b0;
            end
            lost = (idx < 64) && pend_m[idx];
            // raw write races the handler on the ram port
            fork
                send(idx, d, f);
                raw_wr(12'h004, sv);
            join
            if (idx < 64 && ien_m[idx]) pend_m[idx] = 1'b1;
            chk("object head", 1'b1, 12'(TAB + 12 * idx), exp_head(f, ien_m[idx], lost));
            chk("data bytes 1-4", 1'b1, 12'(TAB + 12 * idx + 4), d[31:0]);
            chk("data bytes 5-8", 1'b1, 12'(TAB + 12 * idx + 8), d[63:32]);
            chk("scratch word", 1'b1, 12'h004, sv);
            chk("pending low", 1'b0, 12'(HR_PEND_LO), pend_m[31:0]);
            chk("pending high", 1'b0, 12'(HR_PEND_HI), pend_m[63:32]);
            check("irq", 32'(|pend_m), 32'(irq_o));
        end
        raw_rd(12'h800);
        raw_rd(12'h804);
        chk("unmapped word", 1'b1, 12'h810, 32'h0);
        // snapshot of a finished object, then of the same object under read
        raw_wr(TAB, 32'h0000_1000);
        pend_m[0] = 1'b0;
        f = 20'($urandom);
        d = {$urandom, $urandom};
        send(0, d, f);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, 1'b0, HR_CMD, 32'h0);
            n = 0;
            rd(HR_STATUS);
            while (rd_v[ST_BUSY] !== 1'b0 && n < 20) begin
                rd(HR_STATUS);
                n++;
            end
            check("snapshot status", (s == 0) ? 32'h2 : 32'h8, rd_v);
        end
        chk("snapshot word 1", 1'b0, 12'(HR_SNAP1), d[31:0]);
        chk("pending after read", 1'b0, 12'(HR_PEND_LO), pend_m[31:0]);
        // new frame while the object is marked as under read
        send(0, d, f);
        pend_m[0] = 1'b1;
        chk("pending set again", 1'b0, 12'(HR_PEND_LO), pend_m[31:0]);
        chk("head after reread", 1'b1, TAB, exp_head(f, 1'b1, 1'b0));
        filter_off_i <= 1'b1;
        raw_wr(12'h808, 32'h0);
        repeat (3) @(posedge clk_i);
        check("irq gated off", 32'h0, 32'(irq_o));
        raw_wr(12'h808, 32'h1);
        repeat (3) @(posedge clk_i);
        check("irq gated on", 32'h1, 32'(irq_o));
        give_verdict();
    end
endmodule : test_can_rx_object_store_irq
